// *** hdl/dtc_timer_pair.v ***
// Dual timer/counter with four modes behind an AXI4-Lite register slave.
//
// Design decision made here: the AXI4-Lite slave port.

`include "dtc_regs.vh"

`default_nettype none

module dtc_timer_pair (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire t0_count_pin,
  input wire t1_count_pin,
  input wire ext_irq0_pin_n,
  input wire ext_irq1_pin_n,
  input wire t0_overflow_ack,
  input wire t1_overflow_ack,
  input wire ext_irq0_ack,
  input wire ext_irq1_ack,
  output reg t0_overflow_flag,
  output reg t1_overflow_flag,
  output reg ext_irq0_edge_flag,
  output reg ext_irq1_edge_flag,
  output reg t1_overflow_pulse
);

  function [2:0] dtc_decode;
    input [7:0] addr;
    begin
      case (addr)
        `DTC_ADDR_TCS: dtc_decode = `DTC_IDX_TCS;
        `DTC_ADDR_TMC: dtc_decode = `DTC_IDX_TMC;
        `DTC_ADDR_T0L: dtc_decode = `DTC_IDX_T0L;
        `DTC_ADDR_T1L: dtc_decode = `DTC_IDX_T1L;
        `DTC_ADDR_T0H: dtc_decode = `DTC_IDX_T0H;
        `DTC_ADDR_T1H: dtc_decode = `DTC_IDX_T1H;
        default: dtc_decode = `DTC_IDX_NONE;
      endcase
    end
  endfunction

  // Returns {overflow, high byte, low byte} after one count step.
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg [13:0] sum13;
    reg [16:0] sum16;
    reg [8:0] sum8;
    begin
      sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      sum16 = {1'b0, hi, lo} + 17'h0_0001;
      sum8 = {1'b0, lo} + 9'h001;
      case (mode)
        `DTC_MODE_13BIT:
          // The three upper low-byte bits are left as they are.
          dtc_step = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]};
        `DTC_MODE_16BIT:
          dtc_step = sum16;
        `DTC_MODE_RELOAD:
          dtc_step = sum8[8] ? {1'b1, hi, hi} :
            {1'b0, hi, sum8[7:0]};
        default:
          dtc_step = {sum8[8], hi, sum8[7:0]};
      endcase
    end
  endfunction

  reg [7:0] timer_mode_config;
  reg t0_run_bit;
  reg t1_run_bit;
  reg ext_irq0_trigger_type;
  reg ext_irq1_trigger_type;
  reg [7:0] t0_low_byte;
  reg [7:0] t0_high_byte;
  reg [7:0] t1_low_byte;
  reg [7:0] t1_high_byte;
  reg [2:0] mc_count;
  reg mc_en;
  reg [3:0] pin_filt;
  reg [1:0] count_sample;
  reg [1:0] irq_prev;
  reg [7:0] aw_addr;
  reg aw_got;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_got;

  wire [3:0] pin_raw = {~ext_irq1_pin_n, ~ext_irq0_pin_n,
    t1_count_pin, t0_count_pin};

  // Three-stage synchroniser: the level moves once stages 2 and 3 agree.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          pin_filt[gi] <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_filt[gi] <= s3;
          end
        end
      end
    end
  endgenerate

  // Index 2 and 3 of pin_filt hold the interrupt pins as active high.
  wire irq0_low = pin_filt[2];
  wire irq1_low = pin_filt[3];
  wire [1:0] mode0 = timer_mode_config[`DTC_TMC_MODE0_HI:`DTC_TMC_MODE0_LO];
  wire [1:0] mode1 = timer_mode_config[`DTC_TMC_MODE1_HI:`DTC_TMC_MODE1_LO];
  wire split0 = (mode0 == `DTC_MODE_SPLIT);

  // Falling edges on the count pins, judged on machine-cycle samples.
  wire [1:0] count_edge =
    {2{mc_en}} & count_sample & ~pin_filt[1:0];
  wire t0_src = timer_mode_config[`DTC_TMC_CT0] ? count_edge[0] : mc_en;
  wire t1_src = timer_mode_config[`DTC_TMC_CT1] ? count_edge[1] : mc_en;
  wire t0_open = ~timer_mode_config[`DTC_TMC_GATE0] | ~irq0_low;
  wire t1_open = ~timer_mode_config[`DTC_TMC_GATE1] | ~irq1_low;
  // While timer 0 is split, only its own mode field switches timer 1.
  wire t1_run = (split0 | t1_run_bit) &
    (mode1 != `DTC_MODE_SPLIT);
  wire t0_tick = t0_run_bit & t0_open & t0_src;
  wire t1_tick = t1_run & t1_open & t1_src;
  wire th0_tick = split0 & t1_run_bit & mc_en;

  wire [16:0] t0_next = dtc_step(mode0, t0_high_byte, t0_low_byte);
  wire [16:0] t1_next = dtc_step(mode1, t1_high_byte, t1_low_byte);
  wire [8:0] th0_inc = {1'b0, t0_high_byte} + 9'h001;
  wire t0_ovf = t0_tick & t0_next[16];
  wire t1_ovf = t1_tick & t1_next[16];
  wire th0_ovf = th0_tick & th0_inc[8];
  wire t1_flag_set = (t1_ovf & ~split0) | th0_ovf;

  // Edge mode sets on a falling edge; level mode tracks the low pin.
  wire irq0_set = ext_irq0_trigger_type ?
    (irq0_low & ~irq_prev[0]) : irq0_low;
  wire irq1_set = ext_irq1_trigger_type ?
    (irq1_low & ~irq_prev[1]) : irq1_low;

  wire wr_fire = aw_got & w_got & ~s_axi_bvalid;
  wire [2:0] wr_idx = dtc_decode(aw_addr);
  wire [7:0] wr_byte = w_data[7:0];
  wire wr_en = wr_fire & w_strb[0];
  wire wr_tcs = wr_en & (wr_idx == `DTC_IDX_TCS);
  wire [7:0] tcs_value = {t1_overflow_flag, t1_run_bit, t0_overflow_flag,
    t0_run_bit, ext_irq1_edge_flag, ext_irq1_trigger_type,
    ext_irq0_edge_flag, ext_irq0_trigger_type};

  // Machine-cycle divider.
  always @(posedge aclk) begin
    if (!aresetn) begin
      mc_count <= 3'h0;
      mc_en <= 1'b0;
    end else if (mc_count == `DTC_MC_CLKS - 3'h1) begin
      mc_count <= 3'h0;
      mc_en <= 1'b1;
    end else begin
      mc_count <= mc_count + 3'h1;
      mc_en <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_sample <= 2'b00;
      irq_prev <= 2'b00;
    end else begin
      if (mc_en) begin
        count_sample <= pin_filt[1:0];
      end
      irq_prev <= {irq1_low, irq0_low};
    end
  end

  // Control bits and flags. A hardware set wins over a clear in the
  // same cycle; a software write of one also sets a flag.
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_config <= `DTC_TMC_RESET;
      {t1_overflow_flag, t1_run_bit, t0_overflow_flag, t0_run_bit,
        ext_irq1_edge_flag, ext_irq1_trigger_type, ext_irq0_edge_flag,
        ext_irq0_trigger_type} <= `DTC_TCS_RESET;
      t1_overflow_pulse <= 1'b0;
    end else begin
      if (wr_en && wr_idx == `DTC_IDX_TMC) begin
        timer_mode_config <= wr_byte;
      end
      if (wr_tcs) begin
        t1_run_bit <= wr_byte[`DTC_TCS_T1_RUN];
        t0_run_bit <= wr_byte[`DTC_TCS_T0_RUN];
        ext_irq1_trigger_type <= wr_byte[`DTC_TCS_IRQ1_TYPE];
        ext_irq0_trigger_type <= wr_byte[`DTC_TCS_IRQ0_TYPE];
      end
      t1_overflow_flag <= t1_flag_set | (wr_tcs ? wr_byte[`DTC_TCS_T1_OVF] :
        (t1_overflow_flag & ~t1_overflow_ack));
      t0_overflow_flag <= t0_ovf | (wr_tcs ? wr_byte[`DTC_TCS_T0_OVF] :
        (t0_overflow_flag & ~t0_overflow_ack));
      ext_irq1_edge_flag <= irq1_set | (wr_tcs ? wr_byte[`DTC_TCS_IRQ1_FLAG] :
        (ext_irq1_edge_flag & ~ext_irq1_ack));
      ext_irq0_edge_flag <= irq0_set | (wr_tcs ? wr_byte[`DTC_TCS_IRQ0_FLAG] :
        (ext_irq0_edge_flag & ~ext_irq0_ack));
      t1_overflow_pulse <= t1_ovf;
    end
  end

  // Counter bytes. A software write to a byte wins over a count step.
  always @(posedge aclk) begin
    if (!aresetn) begin
      t0_low_byte <= 8'h00;
      t0_high_byte <= 8'h00;
      t1_low_byte <= 8'h00;
      t1_high_byte <= 8'h00;
    end else begin
      if (wr_en && wr_idx == `DTC_IDX_T0L) begin
        t0_low_byte <= wr_byte;
      end else if (t0_tick) begin
        t0_low_byte <= t0_next[7:0];
      end
      if (wr_en && wr_idx == `DTC_IDX_T0H) begin
        t0_high_byte <= wr_byte;
      end else if (th0_tick) begin
        t0_high_byte <= th0_inc[7:0];
      end else if (t0_tick) begin
        t0_high_byte <= t0_next[15:8];
      end
      if (wr_en && wr_idx == `DTC_IDX_T1L) begin
        t1_low_byte <= wr_byte;
      end else if (t1_tick) begin
        t1_low_byte <= t1_next[7:0];
      end
      if (wr_en && wr_idx == `DTC_IDX_T1H) begin
        t1_high_byte <= wr_byte;
      end else if (t1_tick) begin
        t1_high_byte <= t1_next[15:8];
      end
    end
  end

  // Write channels: address and data are latched independently, and the
  // response follows once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == `DTC_IDX_NONE) ?
          `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  reg [7:0] rd_byte;
  reg [2:0] rd_idx;
  always @* begin
    rd_idx = dtc_decode(s_axi_araddr);
    case (rd_idx)
      `DTC_IDX_TCS: rd_byte = tcs_value;
      `DTC_IDX_TMC: rd_byte = timer_mode_config;
      `DTC_IDX_T0L: rd_byte = t0_low_byte;
      `DTC_IDX_T1L: rd_byte = t1_low_byte;
      `DTC_IDX_T0H: rd_byte = t0_high_byte;
      `DTC_IDX_T1H: rd_byte = t1_high_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read channel: one read in flight, data registered on the same edge
  // that takes the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DTC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= (rd_idx == `DTC_IDX_NONE) ?
          `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** hdl/dtc_regs.vh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// Byte offsets on the register bus.
`define DTC_ADDR_TCS 8'h88
`define DTC_ADDR_TMC 8'h8C
`define DTC_ADDR_T0L 8'h90
`define DTC_ADDR_T1L 8'h94
`define DTC_ADDR_T0H 8'h98
`define DTC_ADDR_T1H 8'h9C

// Register indices used by the decoder.
`define DTC_IDX_NONE 3'h0
`define DTC_IDX_TCS 3'h1
`define DTC_IDX_TMC 3'h2
`define DTC_IDX_T0L 3'h3
`define DTC_IDX_T1L 3'h4
`define DTC_IDX_T0H 3'h5
`define DTC_IDX_T1H 3'h6

// Fields of timer_control_status.
`define DTC_TCS_T1_OVF 7
`define DTC_TCS_T1_RUN 6
`define DTC_TCS_T0_OVF 5
`define DTC_TCS_T0_RUN 4
`define DTC_TCS_IRQ1_FLAG 3
`define DTC_TCS_IRQ1_TYPE 2
`define DTC_TCS_IRQ0_FLAG 1
`define DTC_TCS_IRQ0_TYPE 0
`define DTC_TCS_RESET 8'h00

// Fields of timer_mode_config.
`define DTC_TMC_GATE1 7
`define DTC_TMC_CT1 6
`define DTC_TMC_MODE1_HI 5
`define DTC_TMC_MODE1_LO 4
`define DTC_TMC_GATE0 3
`define DTC_TMC_CT0 2
`define DTC_TMC_MODE0_HI 1
`define DTC_TMC_MODE0_LO 0
`define DTC_TMC_RESET 8'h00

// Timer modes.
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// One machine cycle in clock periods.
`define DTC_MC_CLKS 3'h6

// Bus responses.
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// *** verif/dtc_timer_pair_checker.sv ***
// Concurrent checks on the ports of the dual timer/counter.
`default_nettype none
module dtc_timer_pair_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic t0_overflow_ack,
  input wire logic t1_overflow_ack,
  input wire logic ext_irq0_ack,
  input wire logic ext_irq1_ack,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic ext_irq0_edge_flag,
  input wire logic ext_irq1_edge_flag,
  input wire logic t1_overflow_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // A high awready means no write can land at the next edge.
  chk_t1_flag_holds: assert property (
    t1_overflow_flag && !t1_overflow_ack && s_axi_awready
    |=> t1_overflow_flag) else $error("t1 flag dropped");
  chk_t0_flag_holds: assert property (
    t0_overflow_flag && !t0_overflow_ack && s_axi_awready
    |=> t0_overflow_flag) else $error("t0 flag dropped");
  chk_irq1_flag_holds: assert property (
    ext_irq1_edge_flag && !ext_irq1_ack && s_axi_awready
    |=> ext_irq1_edge_flag) else $error("irq1 flag dropped");
  chk_irq0_flag_holds: assert property (
    ext_irq0_edge_flag && !ext_irq0_ack && s_axi_awready
    |=> ext_irq0_edge_flag) else $error("irq0 flag dropped");
  chk_pulse_spacing: assert property (
    t1_overflow_pulse |=> (!t1_overflow_pulse) [*5])
    else $error("overflow pulses closer than a machine cycle");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_read_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && (s_axi_araddr < 8'h88 ||
    s_axi_araddr > 8'h9C || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule
bind dtc_timer_pair dtc_timer_pair_checker u_chk (.*);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the dual timer/counter.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, t1_overflow_pulse;
  logic [7:0] s_axi_awaddr, s_axi_araddr, r, m;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, pin, ack;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic t0_overflow_flag, t1_overflow_flag;
  logic ext_irq0_edge_flag, ext_irq1_edge_flag;
  wire logic t0_count_pin = pin[0];
  wire logic t1_count_pin = pin[1];
  wire logic ext_irq0_pin_n = pin[2];
  wire logic ext_irq1_pin_n = pin[3];
  wire logic t0_overflow_ack = ack[0];
  wire logic t1_overflow_ack = ack[1];
  wire logic ext_irq0_ack = ack[2];
  wire logic ext_irq1_ack = ack[3];
  wire logic [3:0] flg = {ext_irq1_edge_flag, ext_irq0_edge_flag,
    t1_overflow_flag, t0_overflow_flag};
  logic [7:0] tl_e[3] = '{8'hE0, 8'h00, 8'hFF};
  logic [7:0] th_e[3] = '{8'h00, 8'h00, 8'hFF};
  logic [33:0] exp_q[$];
  int miscompares, total_checks, n;
  dtc_timer_pair u_dtc_timer_pair (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Responses are matched in issue order; one transfer is open at a time.
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, d, input logic [1:0] e = 2'h0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    exp_q.push_back({e, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // A late bready makes the slave hold its response for a while.
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, d, input logic [1:0] e = 2'h0);
    exp_q.push_back({e, 24'h00_0000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wt(input int i);
    n = 0;
    while (flg[i] !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk({33'h0, flg[i]}, 34'h1);
  endtask
  task automatic ackp(input int i);
    ack <= 4'(4'h1 << i);
    @(posedge aclk);
    ack <= 4'h0;
    @(posedge aclk);
  endtask
  // Each level is held past one machine cycle plus the pin synchroniser.
  task automatic fall(input int i);
    pin[i] <= 1'b0;
    repeat (15) @(posedge aclk);
    pin[i] <= 1'b1;
    repeat (15) @(posedge aclk);
  endtask
  task automatic cnt(input int c, input int e);
    n = 0;
    repeat (c) begin
      @(posedge aclk);
      if (t1_overflow_pulse === 1'b1)
        n++;
    end
    chk(34'(n), 34'(e));
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    miscompares++;
    complete_run();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ack} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    pin = 4'hF;
    r = 8'($urandom(32'he98e_a768));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h88, 8'h00);
    rd(8'h8C, 8'h00);
    rd(8'h80, 8'h00, 2'h2);
    wr(8'hA0, 8'h55, 2'h2);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(8'h90 + 8'(4 * i), r);
      rd(8'h90 + 8'(4 * i), r);
    end
    $display("test registers done");
    wr(8'h8C, 8'h02);
    wr(8'h98, 8'hFF);
    wr(8'h90, 8'hFF);
    wr(8'h88, 8'h10);
    wt(0);
    wr(8'h88, 8'h20);
    rd(8'h98, 8'hFF);
    rd(8'h90, 8'hFF);
    ackp(0);
    repeat (30) @(posedge aclk);
    rd(8'h88, 8'h00);
    $display("test reload done");
    wr(8'h8C, 8'h20);
    wr(8'h9C, 8'hFF);
    wr(8'h94, 8'hFF);
    wr(8'h88, 8'h40);
    cnt(60, 10);
    wt(1);
    wr(8'h8C, 8'h30);
    cnt(60, 0);
    wr(8'h88, 8'h80);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h00);
    $display("test machine cycle done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h8C, 8'h0C | 8'(k));
      wr(8'h98, 8'hFF);
      wr(8'h90, 8'hFF);
      wr(8'h88, 8'h10);
      fall(0);
      rd(8'h88, 8'h30);
      wr(8'h88, 8'h00);
      rd(8'h90, tl_e[k]);
      rd(8'h98, th_e[k]);
    end
    wr(8'h8C, 8'h0D);
    wr(8'h90, 8'h00);
    wr(8'h98, 8'h00);
    wr(8'h88, 8'h10);
    pin[2] <= 1'b0;
    repeat (10) @(posedge aclk);
    fall(0);
    pin[2] <= 1'b1;
    repeat (10) @(posedge aclk);
    fall(0);
    wr(8'h88, 8'h00);
    rd(8'h90, 8'h01);
    wr(8'h8C, 8'h60);
    wr(8'h88, 8'h40);
    fall(1);
    rd(8'h88, 8'hC0);
    wr(8'h88, 8'h00);
    $display("test counter done");
    for (int i = 0; i < 2; i++) begin
      m = 8'(8'h01 << (2 * i));
      wr(8'h88, m);
      ackp(2 + i);
      fall(2 + i);
      wt(2 + i);
      rd(8'h88, m | m << 1);
      ackp(2 + i);
      rd(8'h88, m);
      wr(8'h88, 8'h00);
      pin[2 + i] <= 1'b0;
      repeat (10) @(posedge aclk);
      ackp(2 + i);
      rd(8'h88, m << 1);
      pin[2 + i] <= 1'b1;
      repeat (10) @(posedge aclk);
      wr(8'h88, 8'h00);
      rd(8'h88, 8'h00);
    end
    $display("test external done");
    wr(8'h8C, 8'h23);
    cnt(60, 10);
    rd(8'h88, 8'h00);
    wr(8'h8C, 8'h33);
    cnt(60, 0);
    wr(8'h98, 8'hFF);
    wr(8'h90, 8'hFF);
    wr(8'h88, 8'h10);
    wt(0);
    rd(8'h88, 8'h30);
    wr(8'h88, 8'h40);
    wt(1);
    $display("test split done");
    complete_run();
  end
endmodule
`default_nettype wire
